// ===== verilog/whs_dev.sv
// Device end of the host serial port; DMA bytes are buffered in whs_fifo.
// Assumes pins arrive asynchronously; ref_clk well above the link clock.
`timescale 1ns/1ps
module whs_dev
   import whs_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        ce,
   input  wire logic [1:0]  mode,
   output logic [7:0]       reg_addr,
   output logic [7:0]       reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input  wire logic [7:0]  reg_rdata,
   output logic             dma_start,
   input  wire logic        dma_valid,
   output logic             dma_ready,
   input  wire logic [7:0]  dma_data,
   input  wire logic        irq_event,
   output logic             port_active,
   whs_if.dev               bus
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [5:0] pin_s0;
   logic [5:0] pin_s1;
   logic       sck_d;
   logic       ss_d;
   logic       rstn_d;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pin_s0 <= '0;
         pin_s1 <= '0;
         sck_d  <= 1'b0;
         ss_d   <= 1'b1;
         rstn_d <= 1'b0;
      end else if (ce) begin
         pin_s0 <= {bus.cfg_strap, bus.chip_reset_n, bus.chip_en, bus.mosi,
                    bus.slave_select_n, bus.sck};
         pin_s1 <= pin_s0;
         sck_d  <= pin_s1[0];
         ss_d   <= pin_s1[1];
         rstn_d <= pin_s1[4];
      end
   end
   wire sck_s   = pin_s1[0];
   wire ss_n_s  = pin_s1[1];
   wire mosi_s  = pin_s1[2];
   wire en_s    = pin_s1[3];
   wire rstn_s  = pin_s1[4];
   wire strap_s = pin_s1[5];

   // ----------------------------------------------------------------
   // Power and strap
   // ----------------------------------------------------------------
   logic     strap_ok;
   whs_dst_t state;
   wire power_ok = en_s & rstn_s;
   // Strap is caught at the reset release, not sampled afterwards
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         strap_ok <= 1'b0;
      end else if (ce) begin
         if (!power_ok) begin
            strap_ok <= 1'b0;
         end else if (!rstn_d) begin
            strap_ok <= strap_s;
         end
      end
   end
   wire active = strap_ok & power_ok;

   // ----------------------------------------------------------------
   // Clock edges and mode
   // ----------------------------------------------------------------
   wire rise       = sck_s & ~sck_d;
   wire fall       = ~sck_s & sck_d;
   wire leading    = mode[MODE_CPOL_BIT] ? fall : rise;
   wire trailing   = mode[MODE_CPOL_BIT] ? rise : fall;
   wire selected   = (state == DST_XFER) & ~ss_n_s;
   wire sample_e   = selected & (mode[MODE_CPHA_BIT] ? trailing : leading);
   wire shift_e    = selected & (mode[MODE_CPHA_BIT] ? leading : trailing);
   wire frame_beg  = active & ~ss_n_s & ss_d;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state <= DST_OFF;
      end else if (ce) begin
         case (state)
            DST_OFF:  state <= active ? DST_IDLE : DST_OFF;
            DST_IDLE: state <= !active ? DST_OFF : (frame_beg ? DST_XFER : DST_IDLE);
            DST_XFER: state <= !active ? DST_OFF : (ss_n_s ? DST_IDLE : DST_XFER);
            default:  state <= DST_OFF;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Shifters and byte decode
   // ----------------------------------------------------------------
   logic [6:0] rx_sr;
   logic [2:0] bit_cnt;
   logic [1:0] idx;
   logic [7:0] cmd;
   logic [7:0] tx_sr;
   logic [7:0] tx_hold;
   logic       rd_cap;
   logic       pop_req;
   logic       irq_pending;
   logic       fifo_valid;
   logic [7:0] fifo_data;

   wire [7:0] rx_byte   = {rx_sr, mosi_s};
   wire       byte_done = sample_e & (bit_cnt == BIT_LAST);
   wire       at_cmd    = byte_done & (idx == IDX_CMD);
   wire       at_addr   = byte_done & (idx == IDX_ADDR);
   wire       at_data   = byte_done & (idx == IDX_DATA);
   wire       irq_ack   = at_cmd & (rx_byte == CMD_IRQ_ACK);
   wire       do_rd     = (at_addr | at_data) & (cmd == CMD_REG_RD);
   wire       do_wr     = at_data & (cmd == CMD_REG_WR);
   wire       do_dma    = (at_addr | at_data) & (cmd == CMD_DMA_RD);
   wire [7:0] status    = {6'h00, fifo_valid, irq_pending};
   wire [1:0] next_idx  = (idx == IDX_DATA) ? IDX_DATA : idx + 2'h1;

   always_ff @(posedge ref_clk) begin
      if (sys_rst || (ce && !selected)) begin
         rx_sr   <= '0;
         bit_cnt <= '0;
         idx     <= IDX_CMD;
      end else if (ce && sample_e) begin
         rx_sr   <= rx_byte[6:0];
         bit_cnt <= bit_cnt + 3'h1;
         idx     <= (bit_cnt == BIT_LAST) ? next_idx : idx;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cmd <= '0;
      end else if (ce && at_cmd) begin
         cmd <= rx_byte;
      end
   end

   // A fresh byte is loaded at the byte boundary, otherwise shift left
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tx_sr   <= '0;
         tx_hold <= '0;
      end else if (ce) begin
         if (frame_beg) begin
            tx_sr   <= status;
            tx_hold <= status;
         end else begin
            if (shift_e) begin
               tx_sr <= (bit_cnt == '0) ? tx_hold : {tx_sr[6:0], 1'b0};
            end
            if (at_cmd) begin
               tx_hold <= '0;
            end else if (rd_cap) begin
               tx_hold <= reg_rdata;
            end else if (pop_req) begin
               tx_hold <= fifo_valid ? fifo_data : '0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Internal access strobes
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reg_addr  <= '0;
         reg_wdata <= '0;
         reg_wr    <= 1'b0;
         reg_rd    <= 1'b0;
         rd_cap    <= 1'b0;
         pop_req   <= 1'b0;
         dma_start <= 1'b0;
      end else if (ce) begin
         reg_wr    <= do_wr;
         reg_rd    <= do_rd;
         rd_cap    <= reg_rd;
         pop_req   <= do_dma;
         dma_start <= at_addr & (cmd == CMD_DMA_RD);
         if (at_addr) begin
            reg_addr <= rx_byte;
         end else if (reg_wr || rd_cap) begin
            reg_addr <= reg_addr + 8'h01;
         end
         if (do_wr) begin
            reg_wdata <= rx_byte;
         end
      end
   end

   whs_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .ce        (ce),
      .in_valid  (dma_valid),
      .in_ready  (dma_ready),
      .in_data   (dma_data),
      .out_valid (fifo_valid),
      .out_ready (pop_req),
      .out_data  (fifo_data)
   );

   // ----------------------------------------------------------------
   // Interrupt and pin outputs
   // ----------------------------------------------------------------
   // A new event in the acknowledge cycle stays pending
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         irq_pending      <= 1'b0;
         bus.host_interrupt_n <= 1'b1;
         bus.miso_oe      <= 1'b0;
         port_active      <= 1'b0;
      end else if (ce) begin
         irq_pending      <= active & (irq_event | (irq_pending & ~irq_ack));
         bus.host_interrupt_n <= ~irq_pending;
         bus.miso_oe      <= active & ~ss_n_s;
         port_active      <= active;
      end
   end
   assign bus.miso = tx_sr[7];
endmodule // whs_dev

// ===== verilog/whs_pkg.sv
// Shared constants of the host serial port: commands, modes, timing.
// Assumes a 40 MHz ref_clk on both ends.
package whs_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 25;
   localparam int T_RESET_MIN_NS  = 1000;
   localparam int RESET_CYC       = (T_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_SETTLE_MIN_MS = 5;
   localparam int SETTLE_CYC      = (T_SETTLE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
   localparam int F_SCK_MAX_MHZ   = 48;
   // Half period of the host-made serial clock; 40 MHz / 8 = 5 MHz
   localparam int SCK_HALF_DIV    = 4;
   localparam int CNT_W           = 18;
   // -----------------------------------------------------------------
   // Framing
   // -----------------------------------------------------------------
   localparam int BYTE_W     = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int XFER_BITS  = 24;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [4:0] XFER_LAST = 5'h17;
   localparam logic [1:0] IDX_CMD  = 2'h0;
   localparam logic [1:0] IDX_ADDR = 2'h1;
   localparam logic [1:0] IDX_DATA = 2'h2;
   // -----------------------------------------------------------------
   // Commands, modes, status
   // -----------------------------------------------------------------
   localparam logic [7:0] CMD_REG_WR  = 8'h01;
   localparam logic [7:0] CMD_REG_RD  = 8'h02;
   localparam logic [7:0] CMD_DMA_RD  = 8'h03;
   localparam logic [7:0] CMD_IRQ_ACK = 8'h04;
   localparam logic [1:0] MODE_0 = 2'h0;
   localparam logic [1:0] MODE_1 = 2'h1;
   localparam logic [1:0] MODE_2 = 2'h2;
   localparam logic [1:0] MODE_3 = 2'h3;
   localparam int MODE_CPOL_BIT = 1;
   localparam int MODE_CPHA_BIT = 0;
   localparam int STAT_IRQ_BIT  = 0;
   localparam int STAT_DATA_BIT = 1;
   typedef enum logic [2:0] {DST_OFF = 3'b001, DST_IDLE = 3'b010, DST_XFER = 3'b100} whs_dst_t;
   typedef enum logic [3:0] {P_OFF = 4'b0001, P_SETTLE = 4'b0010, P_RESET = 4'b0100,
                             P_ON = 4'b1000} whs_pwr_t;
   typedef enum logic [3:0] {S_IDLE = 4'b0001, S_LEAD = 4'b0010, S_XFER = 4'b0100,
                             S_TAIL = 4'b1000} whs_hst_t;
endpackage

// ===== verilog/whs_if.sv
// Pins between the host controller and the device serial port.
// The released device data line reads low, as if pulled down.
`timescale 1ns/1ps
interface whs_if;
   logic sck;
   logic slave_select_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   wire  miso_line;
   logic host_interrupt_n;
   logic chip_en;
   logic chip_reset_n;
   logic cfg_strap;

   assign miso_line = miso_oe & miso;

   modport dev (input sck, slave_select_n, mosi, chip_en, chip_reset_n, cfg_strap,
                output miso, miso_oe, host_interrupt_n);
   modport host (output sck, slave_select_n, mosi, chip_en, chip_reset_n, cfg_strap,
                 input miso_line, host_interrupt_n);
endinterface

// ===== verilog/whs_host.sv
// Host end: makes the serial clock, runs 3-byte frames in mode 0,
// sequences power-enable and chip reset. Assumes the device end is whs_dev.
// Also holds whs_fifo, the generic FIFO that the device end buffers through.
`timescale 1ns/1ps
module whs_host
   import whs_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYC
) (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        ce,
   input  wire logic        power_on,
   input  wire logic        reset_req,
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic [7:0]  cmd_op,
   input  wire logic [7:0]  cmd_addr,
   input  wire logic [7:0]  cmd_wdata,
   output logic             rsp_valid,
   output logic [7:0]       rsp_status,
   output logic [7:0]       rsp_data,
   output logic             irq_seen,
   output logic             dev_ready,
   whs_if.host              bus
);
   // ----------------------------------------------------------------
   // Power sequencing
   // ----------------------------------------------------------------
   whs_pwr_t         pstate;
   logic [CNT_W-1:0] pcnt;
   wire settle_done = pcnt == CNT_W'(SETTLE_CYCLES - 1);
   wire reset_done  = pcnt == CNT_W'(RESET_CYC - 1);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pstate           <= P_OFF;
         pcnt             <= '0;
         bus.chip_en      <= 1'b0;
         bus.chip_reset_n <= 1'b0;
         bus.cfg_strap    <= 1'b1;
      end else if (ce) begin
         pcnt <= pcnt + CNT_W'(1);
         case (pstate)
            P_OFF: if (power_on) begin
               pstate      <= P_SETTLE;
               pcnt        <= '0;
               bus.chip_en <= 1'b1;
            end
            P_SETTLE: if (!power_on) begin
               pstate      <= P_OFF;
               bus.chip_en <= 1'b0;
            end else if (settle_done) begin
               pstate           <= P_ON;
               bus.chip_reset_n <= 1'b1;
            end
            P_RESET: if (reset_done) begin
               pstate           <= P_ON;
               bus.chip_reset_n <= 1'b1;
            end
            P_ON: if (!power_on) begin
               pstate           <= P_OFF;
               bus.chip_en      <= 1'b0;
               bus.chip_reset_n <= 1'b0;
            end else if (reset_req) begin
               pstate           <= P_RESET;
               pcnt             <= '0;
               bus.chip_reset_n <= 1'b0;
            end
            default: pstate <= P_OFF;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Side-band and data input synchronisers
   // ----------------------------------------------------------------
   logic [1:0] in_s0;
   logic [1:0] in_s1;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         in_s0    <= 2'h3;
         in_s1    <= 2'h3;
         irq_seen <= 1'b0;
      end else if (ce) begin
         in_s0    <= {bus.host_interrupt_n, bus.miso_line};
         in_s1    <= in_s0;
         irq_seen <= ~in_s1[1];
      end
   end
   wire miso_s = in_s1[0];

   // ----------------------------------------------------------------
   // Frame engine, mode 0 only
   // ----------------------------------------------------------------
   // 40 MHz / (2 * SCK_HALF_DIV) stays far below the 48 MHz ceiling
   whs_hst_t       sstate;
   logic [2:0]     div;
   logic [4:0]     nbit;
   logic [23:0]    sh;
   logic [23:0]    rx;
   wire tick   = div == 3'(SCK_HALF_DIV - 1);
   wire accept = cmd_valid & cmd_ready;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sstate             <= S_IDLE;
         div                <= '0;
         nbit               <= '0;
         sh                 <= '0;
         rx                 <= '0;
         bus.sck            <= 1'b0;
         bus.slave_select_n <= 1'b1;
         bus.mosi           <= 1'b0;
      end else if (ce) begin
         div <= tick ? '0 : div + 3'h1;
         case (sstate)
            S_IDLE: if (accept) begin
               sstate             <= S_LEAD;
               div                <= '0;
               nbit               <= '0;
               sh                 <= {cmd_op, cmd_addr, cmd_wdata};
               bus.mosi           <= cmd_op[7];
               bus.slave_select_n <= 1'b0;
            end
            S_LEAD: if (tick) begin
               sstate  <= S_XFER;
               bus.sck <= 1'b1;
            end
            S_XFER: if (tick) begin
               bus.sck <= ~bus.sck;
               if (bus.sck) begin
                  // Sampled at the end of the bit window, after sync delay
                  rx       <= {rx[22:0], miso_s};
                  sh       <= {sh[22:0], 1'b0};
                  bus.mosi <= sh[22];
                  nbit     <= nbit + 5'h01;
                  if (nbit == XFER_LAST) begin
                     sstate  <= S_TAIL;
                     bus.sck <= 1'b0;
                  end
               end
            end
            S_TAIL: if (tick) begin
               sstate             <= S_IDLE;
               bus.slave_select_n <= 1'b1;
               bus.mosi           <= 1'b0;
            end
            default: sstate <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cmd_ready  <= 1'b0;
         rsp_valid  <= 1'b0;
         rsp_status <= '0;
         rsp_data   <= '0;
         dev_ready  <= 1'b0;
      end else if (ce) begin
         dev_ready  <= pstate == P_ON;
         cmd_ready  <= (pstate == P_ON) & (sstate == S_IDLE) & ~accept & ~cmd_ready;
         rsp_valid  <= (sstate == S_TAIL) & tick;
         if ((sstate == S_TAIL) && tick) begin
            rsp_status <= rx[23:16];
            rsp_data   <= rx[7:0];
         end
      end
   end
endmodule // whs_host

module whs_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input  wire logic         ref_clk,
   input  wire logic         sys_rst,
   input  wire logic         ce,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;
   wire           push = in_valid & in_ready;
   wire           pop  = out_valid & out_ready;
   wire [AW:0]    next_count = count + (AW+1)'(push) - (AW+1)'(pop);

   assign out_data = mem[rd_ptr];

   always_ff @(posedge ref_clk) begin
      if (ce && push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end else if (ce) begin
         wr_ptr    <= wr_ptr + AW'(push);
         rd_ptr    <= rd_ptr + AW'(pop);
         count     <= next_count;
         in_ready  <= next_count != (AW+1)'(D);
         out_valid <= next_count != '0;
      end
   end
endmodule // whs_fifo

// ===== tb/whs_props.sv
// Checker for the pins between the host end and the device end.
// Assumes both ends share ref_clk and sys_rst with the bench.
`timescale 1ns/1ps
module whs_props
   import whs_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYC
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic sck,
   input wire logic slave_select_n,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic miso_line,
   input wire logic host_interrupt_n,
   input wire logic chip_en,
   input wire logic chip_reset_n,
   input wire logic cfg_strap
);
   logic [CNT_W-1:0] en_cnt;
   logic [CNT_W-1:0] low_cnt;

   // Saturating, so a long powered stretch never wraps
   always_ff @(posedge ref_clk) begin
      en_cnt  <= (sys_rst || !chip_en) ? '0 : (&en_cnt ? en_cnt : en_cnt + 1'h1);
      low_cnt <= (sys_rst || chip_reset_n) ? '0 : (&low_cnt ? low_cnt : low_cnt + 1'h1);
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   AST_DESEL_Z: assert property (slave_select_n [*5] |-> !miso_oe)
      else $error("data output driven while deselected");
   AST_SEL_DRIVE: assert property (
      (!slave_select_n && chip_en && chip_reset_n) [*8] |-> miso_oe)
      else $error("data output idle inside a frame");
   AST_TX_LINE: assert property (
      miso_oe && sck |-> $stable(miso_line) && miso_line == miso)
      else $error("return line moved while serial clock high");
   AST_STRAP: assert property (cfg_strap)
      else $error("strap pin not held high");
   AST_SCK_IDLE: assert property (slave_select_n |-> !sck)
      else $error("serial clock high outside a frame");
   AST_SCK_HALF: assert property ($rose(sck) |=> sck [*3] ##1 !sck)
      else $error("serial clock high phase not four cycles");
   AST_PWR_OFF: assert property (!chip_en [*5] |-> !miso_oe && host_interrupt_n)
      else $error("device active while powered down");
   AST_SETTLE: assert property ($rose(chip_reset_n) |-> en_cnt >= SETTLE_CYCLES - 1)
      else $error("chip reset released before settle time");
   AST_RST_LEN: assert property ($rose(chip_reset_n) |-> low_cnt >= RESET_CYC - 1)
      else $error("chip reset pulse too short");
   AST_IRQ_HOLD: assert property ($rose(host_interrupt_n) |->
      !slave_select_n || !chip_en || !chip_reset_n)
      else $error("interrupt released without service");

   cover property ($fell(slave_select_n));
   cover property ($rose(host_interrupt_n));
   cover property ($rose(chip_reset_n));
endmodule // whs_props

// ===== tb/tb.sv
// Bench: host and device ends on one interface, plus a lone device end
// on a second interface whose pins the bench drives, strap low in pass 0 and high in pass 1.
`timescale 1ns/1ps
module tb;
   import whs_pkg::*;
   localparam int SETTLE = 50;
   logic       ref_clk, sys_rst, ce, power_on, reset_req, cmd_valid, irq_event, dma_valid;
   logic [1:0] mode;
   logic [7:0] cmd_op, cmd_addr, cmd_wdata, dma_data;
   logic [7:0] regs [256];
   wire        cmd_ready, rsp_valid, irq_seen, dev_ready, port_active, port2_active;
   wire        reg_wr, reg2_wr, dma_start, dma_ready;
   wire  [7:0] rsp_status, rsp_data, reg_addr, reg_wdata, reg_rdata;
   int         err_total, n_checks, n_wr, n_wr2, n_dma;

   whs_if bus_if();
   whs_if bus2_if();
   whs_dev whs_dev_i (.ref_clk, .sys_rst, .ce, .mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd(),
      .reg_rdata, .dma_start, .dma_valid, .dma_ready, .dma_data, .irq_event, .port_active,
      .bus(bus_if));
   whs_dev whs_dev2_i (.ref_clk, .sys_rst, .ce, .mode, .reg_addr(), .reg_wdata(),
      .reg_wr(reg2_wr), .reg_rd(), .reg_rdata, .dma_start(), .dma_valid, .dma_ready(), .dma_data,
      .irq_event, .port_active(port2_active), .bus(bus2_if));
   whs_host #(.SETTLE_CYCLES(SETTLE)) whs_host_i (.ref_clk, .sys_rst, .ce, .power_on, .reset_req,
      .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_status, .rsp_data,
      .irq_seen, .dev_ready, .bus(bus_if));
   whs_props #(.SETTLE_CYCLES(SETTLE)) whs_props_i (.ref_clk, .sys_rst, .sck(bus_if.sck),
      .slave_select_n(bus_if.slave_select_n), .miso(bus_if.miso), .miso_oe(bus_if.miso_oe),
      .miso_line(bus_if.miso_line), .host_interrupt_n(bus_if.host_interrupt_n),
      .chip_en(bus_if.chip_en), .chip_reset_n(bus_if.chip_reset_n), .cfg_strap(bus_if.cfg_strap));

   // Register file behind the device's register port
   assign reg_rdata = regs[reg_addr];
   always @(posedge ref_clk) begin
      if (reg_wr) regs[reg_addr] <= reg_wdata;
      n_wr  <= n_wr + int'(reg_wr);
      n_wr2 <= n_wr2 + int'(reg2_wr);
      n_dma <= n_dma + int'(dma_start);
   end

   initial begin
      ref_clk = 1'h0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic timed_out(input string what);
      err_total++;
      $display("Error %s expected done seen timeout", what);
      finish_test();
   endtask

   // Holds the request until taken, then waits for the answer
   task automatic cmd(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d);
      int i;
      cmd_op = op;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_valid = 1'h1;
      for (i = 0; i < 20 && cmd_ready !== 1'h1; i++) tick(1);
      if (cmd_ready !== 1'h1) timed_out("cmd_ready");
      tick(1);
      cmd_valid = 1'h0;
      for (i = 0; i < 400 && rsp_valid !== 1'h1; i++) tick(1);
      if (i == 400) timed_out("rsp_valid");
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_power();
      int i;
      power_on = 1'h1;
      for (i = 0; i < 200 && dev_ready !== 1'h1; i++) tick(1);
      if (i == 200) timed_out("dev_ready");
      chk("chip_reset_n", 8'h01, {7'h0, bus_if.chip_reset_n});
      chk("irq_seen idle", 8'h00, {7'h0, irq_seen});
      tick(8);
      chk("port_active", 8'h01, {7'h0, port_active});
      $display("t_power done");
   endtask

   task automatic t_regs();
      cmd(CMD_REG_WR, 8'hA5, 8'h3C);
      chk("reg_wr count", 8'h01, 8'(n_wr));
      chk("reg write", 8'h3C, regs[8'hA5]);
      cmd(CMD_REG_RD, 8'hA5, 8'h00);
      chk("read data", 8'h3C, rsp_data);
      chk("status", 8'h00, rsp_status);
      $display("t_regs done");
   endtask

   task automatic t_irq();
      irq_event = 1'h1;
      tick(1);
      irq_event = 1'h0;
      tick(100);
      chk("irq_seen", 8'h01, {7'h0, irq_seen});
      cmd(CMD_REG_RD, 8'hA5, 8'h00);
      chk("status", 8'h01, rsp_status);
      cmd(CMD_IRQ_ACK, 8'h00, 8'h00);
      tick(10);
      chk("irq_seen", 8'h00, {7'h0, irq_seen});
      $display("t_irq done");
   endtask

   task automatic t_fifo();
      int i;
      int n;
      n = 0;
      dma_valid = 1'h1;
      for (i = 0; i < 40; i++) begin
         dma_data = 8'h40 + 8'(n);
         if (dma_ready === 1'h1) n++;
         tick(1);
      end
      dma_valid = 1'h0;
      chk("fifo fill", 8'(FIFO_DEPTH), 8'(n));
      for (i = 0; i < FIFO_DEPTH + 1; i++) begin
         cmd(CMD_DMA_RD, 8'h00, 8'h00);
         // Each frame pops at its address and data bytes; only the first is returned
         chk("dma data", (i < FIFO_DEPTH / 2) ? 8'h40 + 8'(2 * i) : 8'h00, rsp_data);
         chk("dma status", (i < FIFO_DEPTH / 2) ? 8'h02 : 8'h00, rsp_status);
      end
      chk("dma_start count", 8'(FIFO_DEPTH + 1), 8'(n_dma));
      chk("dma_ready", 8'h01, {7'h0, dma_ready});
      $display("t_fifo done");
   endtask

   task automatic t_reset();
      int i;
      reset_req = 1'h1;
      tick(1);
      reset_req = 1'h0;
      tick(5);
      chk("chip_reset_n", 8'h00, {7'h0, bus_if.chip_reset_n});
      for (i = 0; i < 100 && bus_if.chip_reset_n !== 1'h1; i++) tick(1);
      if (bus_if.chip_reset_n !== 1'h1) timed_out("chip_reset_n");
      tick(10);
      cmd(CMD_REG_RD, 8'hA5, 8'h00);
      chk("read after reset", 8'h3C, rsp_data);
      power_on = 1'h0;
      tick(2);
      chip_en_check: chk("chip_en", 8'h00, {7'h0, bus_if.chip_en});
      tick(8);
      chk("port_active off", 8'h00, {7'h0, port_active});
      $display("t_reset done");
   endtask

   // Pass 0: strap low in mode 0, a whole write frame must be ignored.
   // Pass 1: strap high in mode 3, the same frame must land.
   task automatic t_strap();
      int i;
      int p;
      logic [23:0] w;
      bus2_if.chip_en = 1'h1;
      for (p = 0; p < 2; p++) begin
         w = {CMD_REG_WR, 8'h11, 8'h22};
         bus2_if.cfg_strap = 1'(p);
         mode = (p == 0) ? MODE_0 : MODE_3;
         bus2_if.sck = 1'(p);
         bus2_if.chip_reset_n = 1'h0;
         tick(RESET_CYC);
         bus2_if.chip_reset_n = 1'h1;
         tick(8);
         bus2_if.slave_select_n = 1'h0;
         bus2_if.mosi = w[23];
         for (i = 0; i < 48; i++) begin
            tick(4);
            bus2_if.sck = ~bus2_if.sck;
            if (!bus2_if.sck && i > p) w = w << 1;
            bus2_if.mosi = w[23];
         end
         chk("strap miso_oe", 8'(p), {7'h0, bus2_if.miso_oe});
         tick(4);
         bus2_if.slave_select_n = 1'h1;
         tick(8);
         chk("strap port_active", 8'(p), {7'h0, port2_active});
         chk("strap reg_wr", 8'(p), 8'(n_wr2));
      end
      $display("t_strap done");
   endtask

   initial begin
      {power_on, reset_req, cmd_valid, irq_event, dma_valid} = 5'h0;
      {cmd_op, cmd_addr, cmd_wdata, dma_data} = 32'h0;
      {bus2_if.sck, bus2_if.mosi, bus2_if.chip_en, bus2_if.chip_reset_n} = 4'h0;
      bus2_if.cfg_strap = 1'h0;
      bus2_if.slave_select_n = 1'h1;
      {err_total, n_checks, n_wr, n_wr2, n_dma} = '0;
      ce = 1'h1;
      mode = MODE_0;
      sys_rst = 1'h1;
      tick(10);
      sys_rst = 1'h0;
      t_power();
      t_regs();
      t_irq();
      t_fifo();
      t_reset();
      t_strap();
      finish_test();
   end
endmodule // tb
